// File: disc_bus_pkg.sv
// Constants shared by the disc drive bus front end
`default_nettype none
package disc_bus_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int TAG_NS = 100;
  localparam int TAG_CYC = ((TAG_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
                           (TAG_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_NS = 100;
  localparam int GAP_CYC = ((GAP_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
                           (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] TAG_LAST = 4'(TAG_CYC - 1);
  localparam logic [3:0] GAP_LAST = 4'(GAP_CYC - 1);

  // ----------------------------------------
  // Programmed I/O device codes
  // ----------------------------------------
  localparam logic [5:0] CODE_UNIT = 6'h28;
  localparam logic [5:0] CODE_BUS = 6'h29;
  localparam logic [5:0] CODE_TAG = 6'h2A;
  localparam logic [5:0] CODE_STATUS = 6'h28;

  // ----------------------------------------
  // Host word fields (index 15 is the leftmost bit)
  // ----------------------------------------
  localparam int W_TAG_CTL = 3;
  localparam int W_TAG_HEAD = 2;
  localparam int W_TAG_CYL = 1;
  localparam int W_TAG_UNIT = 0;
  localparam int W_VOL_CAP = 5;
  localparam int W_VOL_WANT = 4;
  localparam logic [3:0] MAX_UNIT = 4'h1;

  // ----------------------------------------
  // Bus bits under the control tag, and the volume bit under the head tag
  // ----------------------------------------
  localparam int B_WRITE = 0;
  localparam int B_READ = 1;
  localparam int B_RTZ = 6;
  localparam int B_VOL = 4;

  // ----------------------------------------
  // Status word bits
  // ----------------------------------------
  localparam int S_SEEK = 7;
  localparam int S_SEL_N = 6;
  localparam int S_HEADS_ON_TRACK_N_N = 4;
  localparam int S_WPROT = 3;
  localparam int S_FAULT = 2;
  localparam int S_READY_N = 0;

  // ----------------------------------------
  // Synchronised drive inputs
  // ----------------------------------------
  localparam int NSYNC = 12;
  localparam int I_FAULT = 0;
  localparam int I_SEEK = 1;
  localparam int I_HEADS_ON_TRACK_N = 2;
  localparam int I_INDEX = 3;
  localparam int I_SECTOR = 4;
  localparam int I_READY = 5;
  localparam int I_WPROT = 6;
  localparam int I_SELD = 7;
  localparam int I_SEEKEND = 8;
  localparam int I_SERVO = 9;
  localparam int I_RDCLK = 10;
  localparam int I_RDDATA = 11;

  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 4;
endpackage
`default_nettype wire

// File: disc_drive_bus_interface.sv
// Drive bus front end: tags, control bus, status word and serial data path
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Write data FIFO
// ----------------------------------------
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic ready_r, ready_nxt, empty, push, pop;

  assign empty = (wp_r == rp_r);
  assign in_ready = ready_r;
  assign out_valid = !empty;
  assign out_data = mem[rp_r[AW-1:0]];
  assign push = in_valid && ready_r;
  assign pop = out_ready && !empty;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    // Ready comes from a flop, so it looks one push ahead
    ready_nxt = (wp_nxt[AW-1:0] != rp_nxt[AW-1:0]) || (wp_nxt[AW] == rp_nxt[AW]);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      ready_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      ready_r <= ready_nxt;
    end
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule

// Operation
// - Only two drives; unit numbers above one are ignored.
// - Cylinder tag pulse latches bus as cylinder address.
// - Volume change on capable drives sends a head tag before cylinder tag.
// - Head tag pulse latches head address plus volume bit.
// - Control tag pulse makes each bus bit a separate function.
// - Ten bus bits mean cylinder, head or control per tag.
// - Write enable and read enable never on together under control tag.
// - Bits 2 and 3 offset servo toward or away from spindle.
// - Bit 4 asks the drive to clear a fault.
// - Bit 5 with write or read enables address mark handling.
// - Bit 6 returns to track zero, head zero, volume zero.
// - Bits 7 and 8 strobe read data early or late.
// - Bit 9 selects the addressed unit.
// - Open cable line drives the interface enable.
// - Unit tag latches four-bit unit number on unit select lines.
// - Write clock and serial data timed from drive servo clock.
// - Status read on code 50 gives 16 bits, reserved bits zero.
// - Seek error status set by drive, cleared only by return to zero.
// - Selected status bit reads zero when drive selected.
// - On cylinder bit active low; write protect bit active high.
// - Fault status bit reads one on drive fault.
// - Ready bit active low; missing, slow or faulted reads one.
// - At most one of cylinder, head and control tags at once.
// - Unit tag high with any tag, for the whole operation.
module disc_drive_bus_interface (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pio_out_stb,
  input wire logic pio_in_stb,
  input wire logic [5:0] pio_code,
  input wire logic [15:0] pio_wdata,
  output logic [15:0] pio_rdata_r,
  output logic pio_ack_r,
  output logic ctl_busy_r,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [15:0] wr_word,
  output logic [15:0] rd_word_r,
  output logic rd_valid_r,
  output logic [9:0] bus_out_r,
  output logic tag_cyl_r,
  output logic tag_head_r,
  output logic tag_ctl_r,
  output logic unit_tag_r,
  output logic [3:0] unit_sel_r,
  output logic cable_ok_r,
  input wire logic drv_fault,
  input wire logic seek_fault_flag,
  input wire logic drv_on_track,
  input wire logic drv_index,
  input wire logic drv_sector,
  input wire logic drv_ready,
  input wire logic write_locked_flag,
  input wire logic drive_selected_ack,
  input wire logic seek_end,
  input wire logic servo_clk,
  input wire logic read_clk,
  input wire logic read_data,
  output logic write_clk_r,
  output logic write_data_r
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [disc_bus_pkg::NSYNC-1:0] raw, s1_r, s2_r, s3_r, filt_r, filt_nxt, rise;
  assign raw = {read_data, read_clk, servo_clk, seek_end, drive_selected_ack,
                write_locked_flag, drv_ready, drv_sector, drv_index, drv_on_track,
                seek_fault_flag, drv_fault};

  genvar gi;
  generate
    for (gi = 0; gi < disc_bus_pkg::NSYNC; gi++) begin : g_sync
      // three stages, accept when last two agree
      always_comb begin
        filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
        rise[gi] = filt_nxt[gi] && !filt_r[gi];
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          filt_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          filt_r[gi] <= filt_nxt[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Tag sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_VOLHEAD, ST_GAP, ST_TAG} tag_state_t;
  typedef enum logic [1:0] {K_CYL, K_HEAD, K_CTL} tag_kind_t;

  tag_state_t state_r, state_nxt;
  tag_kind_t kind_r, kind_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [9:0] bus_r, bus_nxt, bus_out_nxt;
  logic [3:0] unit_r, unit_nxt, head_r, head_nxt;
  logic vol_cap_r, vol_cap_nxt, vol_want_r, vol_want_nxt, vol_sent_r, vol_sent_nxt;
  logic unit_hold_r, unit_hold_nxt, wgate_r, wgate_nxt, seek_r, seek_nxt;
  logic ack_nxt, busy_nxt, unit_tag_nxt;
  logic cyl_nxt, head_tag_nxt, ctl_nxt;
  logic programmed_output_a, programmed_input_a, tag_start, rtz_issue;
  logic [2:0] tag_req;

  function automatic logic [1:0] ones3(input logic [2:0] v);
    ones3 = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
  endfunction

  assign programmed_output_a = pio_out_stb && (state_r == ST_IDLE);
  assign programmed_input_a = pio_in_stb && (pio_code == disc_bus_pkg::CODE_STATUS);
  assign tag_req = {pio_wdata[disc_bus_pkg::W_TAG_CTL], pio_wdata[disc_bus_pkg::W_TAG_HEAD],
                    pio_wdata[disc_bus_pkg::W_TAG_CYL]};
  assign tag_start = (state_r != ST_TAG) && (state_nxt == ST_TAG);
  // return to zero issued with control tag
  assign rtz_issue = tag_start && (kind_nxt == K_CTL) && bus_r[disc_bus_pkg::B_RTZ];

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    cnt_nxt = cnt_r + 4'h1;
    bus_nxt = bus_r;
    unit_nxt = unit_r;
    head_nxt = head_r;
    vol_cap_nxt = vol_cap_r;
    vol_want_nxt = vol_want_r;
    vol_sent_nxt = vol_sent_r;
    unit_hold_nxt = unit_hold_r;
    wgate_nxt = wgate_r;
    ack_nxt = programmed_input_a;
    unique case (state_r)
      ST_IDLE: begin
        cnt_nxt = 4'h0;
        if (programmed_output_a && pio_code == disc_bus_pkg::CODE_UNIT) begin
          // only two drives on the chain
          if (pio_wdata[3:0] <= disc_bus_pkg::MAX_UNIT) begin
            unit_nxt = pio_wdata[3:0];
            vol_cap_nxt = pio_wdata[disc_bus_pkg::W_VOL_CAP];
            vol_want_nxt = pio_wdata[disc_bus_pkg::W_VOL_WANT];
            ack_nxt = 1'b1;
          end
        end else if (programmed_output_a && pio_code == disc_bus_pkg::CODE_BUS) begin
          // bus value meaning set by later tag
          bus_nxt = pio_wdata[9:0];
          ack_nxt = 1'b1;
        end else if (programmed_output_a && pio_code == disc_bus_pkg::CODE_TAG) begin
          // more than one tag is refused
          if (ones3(tag_req) == 2'h0) begin
            unit_hold_nxt = pio_wdata[disc_bus_pkg::W_TAG_UNIT];
            ack_nxt = 1'b1;
          end else if (ones3(tag_req) == 2'h1 &&
                       !(tag_req[2] && bus_r[disc_bus_pkg::B_WRITE] &&
                         bus_r[disc_bus_pkg::B_READ])) begin
            unit_hold_nxt = pio_wdata[disc_bus_pkg::W_TAG_UNIT];
            ack_nxt = 1'b1;
            kind_nxt = tag_req[2] ? K_CTL : (tag_req[1] ? K_HEAD : K_CYL);
            // volume change sends head tag first
            if (tag_req[0] && vol_cap_r && vol_want_r != vol_sent_r) begin
              state_nxt = ST_VOLHEAD;
            end else begin
              state_nxt = ST_TAG;
            end
          end
        end
      end
      ST_VOLHEAD: begin
        if (cnt_r == disc_bus_pkg::TAG_LAST) begin
          vol_sent_nxt = vol_want_r;
          cnt_nxt = 4'h0;
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        if (cnt_r == disc_bus_pkg::GAP_LAST) begin
          cnt_nxt = 4'h0;
          state_nxt = ST_TAG;
        end
      end
      ST_TAG: begin
        if (cnt_r == disc_bus_pkg::TAG_LAST) begin
          state_nxt = ST_IDLE;
          unique case (kind_r)
            K_HEAD: begin
              head_nxt = bus_r[3:0];
              vol_sent_nxt = bus_r[disc_bus_pkg::B_VOL];
            end
            K_CTL: begin
              wgate_nxt = bus_r[disc_bus_pkg::B_WRITE];
              if (bus_r[disc_bus_pkg::B_RTZ]) begin
                head_nxt = 4'h0;
                vol_sent_nxt = 1'b0;
              end
            end
            K_CYL: begin
            end
          endcase
        end
      end
    endcase
    busy_nxt = (state_nxt != ST_IDLE);
    cyl_nxt = (state_nxt == ST_TAG) && (kind_nxt == K_CYL);
    ctl_nxt = (state_nxt == ST_TAG) && (kind_nxt == K_CTL);
    head_tag_nxt = (state_nxt == ST_VOLHEAD) ||
                   ((state_nxt == ST_TAG) && (kind_nxt == K_HEAD));
    // unit tag stands through whole operation
    unit_tag_nxt = unit_hold_nxt || busy_nxt;
    // control bits go out as loaded
    bus_out_nxt = bus_nxt;
    if (state_nxt == ST_VOLHEAD) begin
      bus_out_nxt = {bus_r[9:5], vol_want_r, head_r};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      kind_r <= K_CYL;
      cnt_r <= 4'h0;
      bus_r <= 10'h000;
      unit_r <= 4'h0;
      head_r <= 4'h0;
      vol_cap_r <= 1'b0;
      vol_want_r <= 1'b0;
      vol_sent_r <= 1'b0;
      unit_hold_r <= 1'b0;
      wgate_r <= 1'b0;
      pio_ack_r <= 1'b0;
      ctl_busy_r <= 1'b0;
      bus_out_r <= 10'h000;
      tag_cyl_r <= 1'b0;
      tag_head_r <= 1'b0;
      tag_ctl_r <= 1'b0;
      unit_tag_r <= 1'b0;
      unit_sel_r <= 4'h0;
      cable_ok_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      bus_r <= bus_nxt;
      unit_r <= unit_nxt;
      head_r <= head_nxt;
      vol_cap_r <= vol_cap_nxt;
      vol_want_r <= vol_want_nxt;
      vol_sent_r <= vol_sent_nxt;
      unit_hold_r <= unit_hold_nxt;
      wgate_r <= wgate_nxt;
      pio_ack_r <= ack_nxt;
      ctl_busy_r <= busy_nxt;
      bus_out_r <= bus_out_nxt;
      tag_cyl_r <= cyl_nxt;
      tag_head_r <= head_tag_nxt;
      tag_ctl_r <= ctl_nxt;
      unit_tag_r <= unit_tag_nxt;
      unit_sel_r <= unit_nxt;
      // interface enabled once out of reset
      cable_ok_r <= 1'b1;
    end
  end

  property p_one_tag;
    @(posedge clk) disable iff (!rst_n) $onehot0({tag_cyl_r, tag_head_r, tag_ctl_r});
  endproperty
  a_one_tag: assert property (p_one_tag) else $error("two tags at once");

  property p_unit_with_tag;
    @(posedge clk) disable iff (!rst_n)
      (tag_cyl_r || tag_head_r || tag_ctl_r) |-> unit_tag_r;
  endproperty
  a_unit_with_tag: assert property (p_unit_with_tag) else $error("unit tag missing");

  property p_rw_excl;
    @(posedge clk) disable iff (!rst_n)
      tag_ctl_r |-> !(bus_out_r[disc_bus_pkg::B_WRITE] && bus_out_r[disc_bus_pkg::B_READ]);
  endproperty
  a_rw_excl: assert property (p_rw_excl) else $error("write and read together");

  property p_cyl_width;
    @(posedge clk) disable iff (!rst_n) $rose(tag_cyl_r) |-> tag_cyl_r[*5] ##1 !tag_cyl_r;
  endproperty
  a_cyl_width: assert property (p_cyl_width) else $error("cylinder tag width wrong");

  property p_vol_first;
    @(posedge clk) disable iff (!rst_n)
      ($rose(tag_cyl_r) && vol_cap_r) |-> (vol_sent_r == vol_want_r);
  endproperty
  a_vol_first: assert property (p_vol_first) else $error("volume not sent first");

  property p_bus_stable;
    @(posedge clk) disable iff (!rst_n)
      (tag_ctl_r && $past(tag_ctl_r)) |-> $stable(bus_out_r) && $stable(unit_sel_r);
  endproperty
  a_bus_stable: assert property (p_bus_stable) else $error("bus moved under tag");

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  logic [15:0] status;
  logic [15:0] rdata_nxt;

  always_comb begin
    seek_nxt = filt_r[disc_bus_pkg::I_SEEK] || (seek_r && !rtz_issue);
    status = 16'h0000;
    status[disc_bus_pkg::S_SEEK] = seek_r;
    status[disc_bus_pkg::S_SEL_N] = !filt_r[disc_bus_pkg::I_SELD];
    // on cylinder low, write protect high
    status[disc_bus_pkg::S_HEADS_ON_TRACK_N_N] = !filt_r[disc_bus_pkg::I_HEADS_ON_TRACK_N];
    status[disc_bus_pkg::S_WPROT] = filt_r[disc_bus_pkg::I_WPROT];
    status[disc_bus_pkg::S_FAULT] = filt_r[disc_bus_pkg::I_FAULT];
    // not ready when missing or faulted
    status[disc_bus_pkg::S_READY_N] = !(filt_r[disc_bus_pkg::I_READY] &&
                                        !filt_r[disc_bus_pkg::I_FAULT]);
    rdata_nxt = programmed_input_a ? status : pio_rdata_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seek_r <= 1'b0;
      pio_rdata_r <= 16'h0000;
    end else begin
      seek_r <= seek_nxt;
      pio_rdata_r <= rdata_nxt;
    end
  end

  property p_seek_clear;
    @(posedge clk) disable iff (!rst_n) $fell(seek_r) |-> $past(rtz_issue);
  endproperty
  a_seek_clear: assert property (p_seek_clear) else $error("seek flag lost");

  property p_status_read;
    @(posedge clk) disable iff (!rst_n)
      programmed_input_a |=> pio_ack_r && pio_rdata_r[15:8] == 8'h00 && pio_rdata_r[5] == 1'b0
              && pio_rdata_r[disc_bus_pkg::S_SEL_N] == !$past(filt_r[disc_bus_pkg::I_SELD]);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status word wrong");

  // ----------------------------------------
  // Serial data path
  // ----------------------------------------
  // Servo and read clocks are sampled, so both must stay well under clk/6
  logic fifo_valid, fifo_pop;
  logic [15:0] fifo_word, wsh_r, wsh_nxt, rsh_r, rsh_nxt, rd_word_nxt;
  logic [3:0] wcnt_r, wcnt_nxt, rcnt_r, rcnt_nxt;
  logic wclk_nxt, wdata_nxt, rd_valid_nxt, wload_r, wload_nxt;

  word_fifo #(.WIDTH(disc_bus_pkg::WORD_W), .DEPTH(disc_bus_pkg::FIFO_DEPTH)) i_word_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_word)
  );

  always_comb begin
    wsh_nxt = wsh_r;
    wcnt_nxt = wcnt_r;
    wload_nxt = wload_r;
    fifo_pop = 1'b0;
    // write clock follows servo clock while writing
    wclk_nxt = wgate_r && filt_r[disc_bus_pkg::I_SERVO];
    wdata_nxt = write_data_r;
    if (!wgate_r) begin
      wload_nxt = 1'b0;
      wcnt_nxt = 4'h0;
      wdata_nxt = 1'b0;
    end else if (rise[disc_bus_pkg::I_SERVO]) begin
      if (wload_r && wcnt_r != 4'hF) begin
        wsh_nxt = {wsh_r[14:0], 1'b0};
        wcnt_nxt = wcnt_r + 4'h1;
        wdata_nxt = wsh_r[15];
      end else if (fifo_valid) begin
        fifo_pop = 1'b1;
        wload_nxt = 1'b1;
        wsh_nxt = {fifo_word[14:0], 1'b0};
        wcnt_nxt = 4'h0;
        wdata_nxt = fifo_word[15];
      end else begin
        wload_nxt = 1'b0;
        wdata_nxt = 1'b0;
      end
    end
    rsh_nxt = rsh_r;
    rcnt_nxt = rcnt_r;
    rd_word_nxt = rd_word_r;
    rd_valid_nxt = 1'b0;
    if (rise[disc_bus_pkg::I_RDCLK]) begin
      rsh_nxt = {rsh_r[14:0], filt_r[disc_bus_pkg::I_RDDATA]};
      rcnt_nxt = rcnt_r + 4'h1;
      if (rcnt_r == 4'hF) begin
        rd_word_nxt = {rsh_r[14:0], filt_r[disc_bus_pkg::I_RDDATA]};
        rd_valid_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wsh_r <= 16'h0000;
      wcnt_r <= 4'h0;
      wload_r <= 1'b0;
      write_clk_r <= 1'b0;
      write_data_r <= 1'b0;
      rsh_r <= 16'h0000;
      rcnt_r <= 4'h0;
      rd_word_r <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else begin
      wsh_r <= wsh_nxt;
      wcnt_r <= wcnt_nxt;
      wload_r <= wload_nxt;
      write_clk_r <= wclk_nxt;
      write_data_r <= wdata_nxt;
      rsh_r <= rsh_nxt;
      rcnt_r <= rcnt_nxt;
      rd_word_r <= rd_word_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

endmodule

`default_nettype wire

// File: drive_model.sv
// Behavioural disc drive on the far side of the front end
`timescale 1ns/10ps
`default_nettype none
module drive_model (
  input wire logic [9:0] bus,
  input wire logic tag_ctl,
  input wire logic wclk,
  input wire logic wdata,
  input wire logic servo_on,
  input wire logic fault_src,
  input wire logic on_trk,
  input wire logic seek_err,
  output logic fault = 1'b0,
  output logic chosen = 1'b0,
  output logic seek_end,
  output logic servo = 1'b0,
  output logic rclk = 1'b0,
  output logic rdata = 1'b0,
  output logic [15:0] got = 16'h0000,
  output logic got_v = 1'b0
);
  // ----------------------------------------
  // Drive behaviour
  // ----------------------------------------
  int n = 0;
  assign seek_end = on_trk | seek_err;
  always @(posedge fault_src) fault = 1'b1;
  always @(posedge tag_ctl) begin
    if (bus[4] && !fault_src) fault = 1'b0;
    if (bus[9]) chosen = 1'b1;
  end
  // Servo stands still unless a write is wanted
  always #80 servo = servo_on & ~servo;
  // write bits on falling write clock
  always @(negedge wclk) begin
    got = {got[14:0], wdata};
    n++;
    got_v = (n % 16 == 0);
    #20 got_v = 1'b0;
  end
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      rdata = w[i];
      #80 rclk = 1'b1;
      #80 rclk = 1'b0;
    end
    // Released line shows the inverse of the last bit
    rdata = ~w[0];
  endtask
endmodule
`default_nettype wire

// File: disc_drive_bus_interface_bench.sv
// Self-checking bench for the disc drive bus front end
`timescale 1ns/10ps
`default_nettype none
module disc_drive_bus_interface_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pio_out_stb = 1'b0;
  logic pio_in_stb = 1'b0;
  logic [5:0] pio_code = 6'h00;
  logic [15:0] pio_wdata = 16'h0000;
  logic wr_valid = 1'b0;
  logic [15:0] wr_word = 16'h0000;
  logic fault_src = 1'b0;
  logic seek_fault_flag = 1'b0;
  logic drv_on_track = 1'b0;
  logic drv_index = 1'b0;
  logic drv_sector = 1'b0;
  logic drv_ready = 1'b0;
  logic write_locked_flag = 1'b0;
  logic servo_on = 1'b0;
  logic [15:0] pio_rdata_r, rd_word_r, got;
  logic pio_ack_r, ctl_busy_r, wr_ready, rd_valid_r, tag_cyl_r, tag_head_r, tag_ctl_r;
  logic unit_tag_r, cable_ok_r, drv_fault, drive_selected_ack, seek_end, servo_clk;
  logic read_clk, read_data, write_clk_r, write_data_r, got_v;
  logic [9:0] bus_out_r, head_bus;
  logic [3:0] unit_sel_r;
  logic [15:0] lfsr = 16'h299D;
  logic [16:0] e;
  logic [16:0] pq[$];
  logic [15:0] rq[$];
  logic [15:0] wq[$];
  int tq[$];
  int tlen = 0;
  int bad_count = 0;
  int cmp_count = 0;

  always #10 clk = ~clk;

  disc_drive_bus_interface i_disc_drive_bus_interface (.clk, .rst_n, .pio_out_stb,
    .pio_in_stb, .pio_code, .pio_wdata, .pio_rdata_r, .pio_ack_r, .ctl_busy_r, .wr_valid,
    .wr_ready, .wr_word, .rd_word_r, .rd_valid_r, .bus_out_r, .tag_cyl_r, .tag_head_r,
    .tag_ctl_r, .unit_tag_r, .unit_sel_r, .cable_ok_r, .drv_fault, .seek_fault_flag,
    .drv_on_track, .drv_index, .drv_sector, .drv_ready, .write_locked_flag,
    .drive_selected_ack, .seek_end, .servo_clk, .read_clk, .read_data, .write_clk_r,
    .write_data_r);
  drive_model i_drive_model (.bus(bus_out_r), .tag_ctl(tag_ctl_r), .wclk(write_clk_r),
    .wdata(write_data_r), .servo_on(servo_on), .fault_src(fault_src), .on_trk(drv_on_track),
    .seek_err(seek_fault_flag), .fault(drv_fault), .chosen(drive_selected_ack),
    .seek_end(seek_end), .servo(servo_clk), .rclk(read_clk), .rdata(read_data), .got(got),
    .got_v(got_v));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic pio(input logic rd, input logic [5:0] c, input logic [15:0] d,
                     input logic ok, input logic [15:0] exp);
    @(posedge clk);
    pio_in_stb <= rd;
    pio_out_stb <= ~rd;
    pio_code <= c;
    pio_wdata <= d;
    if (ok) pq.push_back({rd, exp});
    @(posedge clk);
    pio_in_stb <= 1'b0;
    pio_out_stb <= 1'b0;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 40 && ctl_busy_r !== 1'b0; i++) @(negedge clk);
    check("busy_end", ctl_busy_r, 1'b0);
  endtask
  task automatic status(input logic sk, input logic sl, input logic fl);
    pio(1'b1, disc_bus_pkg::CODE_STATUS, 16'h0000, 1'b1, {8'h00, sk, ~sl, 1'b0,
        ~drv_on_track, write_locked_flag, fl, 1'b0, ~(drv_ready & ~fl)});
  endtask
  task automatic push(input logic [15:0] w);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_word <= w;
    wq.push_back(w);
    for (int i = 0; i < 4000; i++) begin
      @(negedge clk);
      if (wr_ready === 1'b1) break;
    end
    check("push_ready", wr_ready, 1'b1);
    @(posedge clk);
    wr_valid <= 1'b0;
  endtask

  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(negedge clk) begin
    if (pio_ack_r === 1'b1) begin
      if (pq.size() == 0) check("unexpected_ack", 1, 0);
      else begin
        e = pq.pop_front();
        if (e[16]) check("status", pio_rdata_r, e[15:0]);
      end
    end
    if (rd_valid_r === 1'b1) check("rd_word", rd_word_r, rq.pop_front());
    if (got_v) check("wr_word", got, wq.pop_front());
    if ((tag_cyl_r | tag_head_r | tag_ctl_r) === 1'b1) begin
      tlen++;
      check("one_tag", tag_cyl_r + tag_head_r + tag_ctl_r, 1);
      check("unit_tag", unit_tag_r, 1);
      if (tlen == 1) tq.push_back(tag_head_r ? 2 : tag_cyl_r ? 1 : 3);
      if (tag_head_r) head_bus = bus_out_r;
    end else if (tlen != 0) begin
      check("tag_len", tlen, 5);
      tlen = 0;
    end
  end

  initial begin
    #300000;
    bad_count++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("cable_ok", cable_ok_r, 1);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      lfsr = nxt(lfsr);
      {fault_src, drv_on_track, drv_ready, write_locked_flag, drv_index, drv_sector} <= lfsr[5:0];
      repeat (8) @(posedge clk);
      status(1'b0, 1'b0, drv_fault);
    end
    @(posedge clk);
    fault_src <= 1'b0;
    seek_fault_flag <= 1'b1;
    repeat (8) @(posedge clk);
    seek_fault_flag <= 1'b0;
    repeat (8) @(posedge clk);
    status(1'b1, 1'b0, drv_fault);
    pio(1'b0, disc_bus_pkg::CODE_UNIT, 16'h0001, 1'b1, 0);
    pio(1'b0, disc_bus_pkg::CODE_BUS, 16'h0250, 1'b1, 0);
    pio(1'b0, disc_bus_pkg::CODE_TAG, 16'h0009, 1'b1, 0);
    repeat (8) @(posedge clk);
    status(1'b0, 1'b1, 1'b0);
    $display("test status done");
    tq.delete();
    pio(1'b0, disc_bus_pkg::CODE_BUS, 16'h0155, 1'b1, 0);
    pio(1'b0, disc_bus_pkg::CODE_TAG, 16'h0003, 1'b1, 0);
    check("bus", bus_out_r, 10'h155);
    check("unit_sel", unit_sel_r, 4'h1);
    check("cyl_tag", tq.pop_front(), 1);
    pio(1'b0, disc_bus_pkg::CODE_UNIT, 16'h0002, 1'b0, 0);
    pio(1'b0, disc_bus_pkg::CODE_TAG, 16'h0007, 1'b0, 0);
    pio(1'b0, disc_bus_pkg::CODE_BUS, 16'h0003, 1'b1, 0);
    pio(1'b0, disc_bus_pkg::CODE_TAG, 16'h0009, 1'b0, 0);
    check("unit_kept", unit_sel_r, 4'h1);
    check("no_tag", tq.size(), 0);
    pio(1'b0, disc_bus_pkg::CODE_UNIT, 16'h0031, 1'b1, 0);
    pio(1'b0, disc_bus_pkg::CODE_BUS, 16'h00AA, 1'b1, 0);
    pio(1'b0, disc_bus_pkg::CODE_TAG, 16'h0003, 1'b1, 0);
    check("head_first", tq.pop_front(), 2);
    check("then_cyl", tq.pop_front(), 1);
    check("vol_bit", head_bus[4], 1'b1);
    pio(1'b0, disc_bus_pkg::CODE_BUS, 16'h0003, 1'b1, 0);
    pio(1'b0, disc_bus_pkg::CODE_TAG, 16'h0005, 1'b1, 0);
    pio(1'b0, disc_bus_pkg::CODE_BUS, 16'h00AA, 1'b1, 0);
    pio(1'b0, disc_bus_pkg::CODE_TAG, 16'h0003, 1'b1, 0);
    check("head_tag", tq.pop_front(), 2);
    check("vol_again", tq.pop_front(), 2);
    check("head_kept", head_bus[4:0], 5'h13);
    $display("test tags done");
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      push(lfsr);
      if (i == 3) begin
        @(negedge clk);
        check("fifo_full", wr_ready, 1'b0);
        pio(1'b0, disc_bus_pkg::CODE_BUS, 16'h0001, 1'b1, 0);
        pio(1'b0, disc_bus_pkg::CODE_TAG, 16'h0009, 1'b1, 0);
        servo_on <= 1'b1;
      end
    end
    for (int i = 0; i < 4000 && wq.size() != 0; i++) @(negedge clk);
    servo_on <= 1'b0;
    pio(1'b0, disc_bus_pkg::CODE_BUS, 16'h0002, 1'b1, 0);
    pio(1'b0, disc_bus_pkg::CODE_TAG, 16'h0009, 1'b1, 0);
    $display("test write done");
    for (int i = 0; i < 2; i++) begin
      lfsr = nxt(lfsr);
      rq.push_back(lfsr);
      i_drive_model.send(lfsr);
    end
    repeat (20) @(posedge clk);
    check("queues_empty", rq.size() + wq.size() + pq.size(), 0);
    $display("test read done");
    conclude();
  end
endmodule
`default_nettype wire
